// >>> rtl/port_e_pkg.sv
package port_e_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_PIN_DATA = 3'h0;
  localparam logic [2:0] ADDR_LATCH = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h4;
  localparam logic [2:0] ADDR_IRQ_CLEAR = 3'h5;
  localparam logic [2:0] ADDR_SLAVE_DATA = 3'h6;

  // Control register fields, reset values and strobe pin indices
  localparam int CTRL_IN_FULL = 7;
  localparam int CTRL_OUT_FULL = 6;
  localparam int CTRL_IN_OVERFLOW = 5;
  localparam int CTRL_MODE = 4;
  localparam logic [2:0] DIR_RESET = 3'h7;
  localparam logic [2:0] LATCH_RESET = 3'h0;
  localparam logic [2:0] ANALOG_RESET = 3'h7;
  localparam int PIN_RD = 0;
  localparam int PIN_WR = 1;
  localparam int PIN_CS = 2;

  // Interrupt status bits
  localparam int IRQ_WRITE_DONE = 0;
  localparam int IRQ_READ_DONE = 1;
  localparam int IRQ_OVERFLOW = 2;
  localparam int IRQ_BITS = 3;

  // External strobe snapshot (active-low on the wire)
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } strobe_s;

endpackage : port_e_pkg

// >>> rtl/port_e_io.sv
`timescale 1ns/10ps
// Function
// - Small package: only bit 3 when clear off
// - Bit 7 read-only, set on received word
// - Bit 6 read-only, high until word read
// - Bit 5 set on write while unread
// - Bit 4 selects slave port mode
// - Bit 3 reads zero, writes ignored
// - Bits 2..0: one input, zero output
// - Output pin driven from latch, even analog
// - Input pin reads level, not when analog
// - Slave mode: pin 0 read strobe
// - Slave mode: pin 1 write strobe
// - Slave mode: pin 2 chip select
// - Reset makes pins 0..2 inputs; analog comes from analog_select
// - Clear enabled: shared pin is reset input
// - Clear disabled: shared pin is data bit 3
// - Data bits 7..4 read zero; latch 3 bits
// - Latch register reads latch, not pins
// - Analog pins read zero
module port_e_io (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic small_package,
  input wire logic master_clear_enable_cfg,
  input wire logic [2:0] analog_select,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  input wire logic port_bit3_input,
  output logic master_clear_req,
  input wire logic [7:0] slave_bus_in,
  output logic [7:0] slave_bus_out,
  output logic slave_bus_oe,
  output logic irq
);

  logic [2:0] latch_r;
  logic [2:0] dir_r;
  logic mode_r;
  // Slave port status flags of the control register
  logic input_buffer_full_r;
  logic output_buffer_full_r;
  logic input_overflow_r;
  logic [7:0] in_word_r;
  logic [7:0] out_word_r;
  logic [2:0] irq_status_r;
  logic [2:0] irq_enable_r;
  port_e_pkg::strobe_s strb_prev_r;
  port_e_pkg::strobe_s strb;
  logic strobes_on;
  logic wr_active;
  logic rd_active;
  logic wr_prev;
  logic rd_prev;
  logic wr_end;
  logic rd_start;
  logic rd_end;
  logic cpu_rd_word;
  logic cpu_wr_word;
  logic [7:0] rdata_nxt;
  logic [2:0] dig_in;

  // Strobes only act in slave mode with all three pins as inputs
  assign strobes_on = mode_r && (dir_r == 3'h7);
  assign strb.rd_n = pin_in[port_e_pkg::PIN_RD];
  assign strb.wr_n = pin_in[port_e_pkg::PIN_WR];
  assign strb.cs_n = pin_in[port_e_pkg::PIN_CS];
  assign wr_active = strobes_on && !strb.cs_n && !strb.wr_n;
  assign rd_active = strobes_on && !strb.cs_n && !strb.rd_n;
  assign wr_prev = !strb_prev_r.cs_n && !strb_prev_r.wr_n;
  assign rd_prev = !strb_prev_r.cs_n && !strb_prev_r.rd_n;
  // A transfer ends when either line returns high
  assign wr_end = wr_prev && !wr_active;
  assign rd_start = rd_active && !rd_prev;
  assign rd_end = rd_prev && !rd_active;
  assign cpu_rd_word = reg_rd && reg_addr == port_e_pkg::ADDR_SLAVE_DATA;
  assign cpu_wr_word = reg_wr && reg_addr == port_e_pkg::ADDR_SLAVE_DATA;

  // Digital input path is cut when a pin is analog
  assign dig_in = pin_in & ~analog_select;

  // Previous strobe levels, forced idle outside slave mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strb_prev_r <= '1;
    end else if (strobes_on) begin
      strb_prev_r <= strb;
    end else begin
      strb_prev_r <= '1;
    end
  end

  // Output latch and direction, buffer full flags are not writable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      latch_r <= port_e_pkg::LATCH_RESET;
      dir_r <= port_e_pkg::DIR_RESET;
      mode_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == port_e_pkg::ADDR_LATCH ||
          reg_addr == port_e_pkg::ADDR_PIN_DATA) begin
        latch_r <= reg_wdata[2:0];
      end
      if (reg_addr == port_e_pkg::ADDR_CTRL) begin
        dir_r <= reg_wdata[2:0];
        mode_r <= reg_wdata[port_e_pkg::CTRL_MODE];
      end
    end
  end

  // Input buffer: data taken while the write is active, because the
  // master may change the bus as soon as it lifts a strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      input_buffer_full_r <= 1'b0;
      in_word_r <= 8'h00;
    end else begin
      if (wr_active) begin
        in_word_r <= slave_bus_in;
      end
      // Flag set when the write ends; set wins over a CPU read
      if (wr_end) begin
        input_buffer_full_r <= 1'b1;
      end else if (cpu_rd_word) begin
        input_buffer_full_r <= 1'b0;
      end
    end
  end

  // Overflow: set wins over software clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      input_overflow_r <= 1'b0;
    end else if (wr_end && input_buffer_full_r) begin
      input_overflow_r <= 1'b1;
    end else if (reg_wr && reg_addr == port_e_pkg::ADDR_CTRL &&
                 !reg_wdata[port_e_pkg::CTRL_IN_OVERFLOW]) begin
      input_overflow_r <= 1'b0;
    end
  end

  // Output buffer: full after CPU write, empties on external read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      output_buffer_full_r <= 1'b0;
      out_word_r <= 8'h00;
    end else begin
      if (cpu_wr_word) begin
        out_word_r <= reg_wdata;
      end
      // A write during an active read goes straight out, flag stays low
      if (cpu_wr_word && !rd_active) begin
        output_buffer_full_r <= 1'b1;
      end else if (rd_start) begin
        output_buffer_full_r <= 1'b0;
      end
    end
  end

  // Pin drivers: output when direction bit is zero, analog or not
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
    end else begin
      pin_out <= latch_r;
      pin_oe <= ~dir_r;
    end
  end

  // Slave data bus driven only while a read is in progress
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slave_bus_out <= 8'h00;
      slave_bus_oe <= 1'b0;
    end else begin
      slave_bus_out <= cpu_wr_word ? reg_wdata : out_word_r;
      slave_bus_oe <= rd_active;
    end
  end

  // Shared pin as reset request, only where clear is enabled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      master_clear_req <= 1'b0;
    end else begin
      master_clear_req <= master_clear_enable_cfg &&
                          !port_bit3_input;
    end
  end

  // Interrupt status: events set, clear register clears, set wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_status_r <= '0;
      irq_enable_r <= '0;
    end else begin
      if (reg_wr && reg_addr == port_e_pkg::ADDR_IRQ_ENABLE) begin
        irq_enable_r <= reg_wdata[2:0];
      end
      irq_status_r <= (irq_status_r &
        ~((reg_wr && reg_addr == port_e_pkg::ADDR_IRQ_CLEAR) ?
          reg_wdata[2:0] : 3'h0)) |
        {wr_end && input_buffer_full_r, rd_end, wr_end};
    end
  end

  // Level interrupt, registered so the pin never glitches
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_enable_r);
    end
  end

  // Read mux; small package hides pin data bits 2..0
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      port_e_pkg::ADDR_PIN_DATA: begin
        if (!master_clear_enable_cfg) begin
          rdata_nxt[3] = port_bit3_input;
        end
        if (!small_package) begin
          rdata_nxt[2:0] = dig_in;
        end
      end
      port_e_pkg::ADDR_LATCH: rdata_nxt[2:0] = latch_r;
      port_e_pkg::ADDR_CTRL: begin
        rdata_nxt = {input_buffer_full_r, output_buffer_full_r,
                     input_overflow_r, mode_r,
                     1'b0, dir_r};
      end
      port_e_pkg::ADDR_IRQ_STATUS: rdata_nxt[2:0] = irq_status_r;
      port_e_pkg::ADDR_IRQ_ENABLE: rdata_nxt[2:0] = irq_enable_r;
      port_e_pkg::ADDR_SLAVE_DATA: rdata_nxt = in_word_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stand for one cycle only and are zero otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // A finished external write raises the input full flag
  a_input_full_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    wr_end |=> input_buffer_full_r)
    else $error("input full not set");

  // A write onto an unread word raises overflow
  a_overflow_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    (wr_end && input_buffer_full_r) |=> input_overflow_r)
    else $error("overflow lost");

  // An external read empties the output buffer
  a_output_full_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    (rd_start && !cpu_wr_word) |=> !output_buffer_full_r)
    else $error("output full stuck");

  // Pins follow latch and direction, analog or not
  a_pin_drive: assert property (
    @(posedge mclk) disable iff (!nrst)
    1'b1 |=> pin_oe == ~$past(dir_r) && pin_out == $past(latch_r))
    else $error("pin drive wrong");

  // Unused control bit always reads zero
  a_bit3_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == port_e_pkg::ADDR_CTRL |=> !reg_rdata[3])
    else $error("bit 3 nonzero");

  // Upper data bits always read zero
  a_high_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == port_e_pkg::ADDR_PIN_DATA
    |=> reg_rdata[7:4] == 4'h0) else $error("data high bits");

  // No reset request while the shared pin is plain data
  a_clear_req_off: assert property (
    @(posedge mclk) disable iff (!nrst)
    !master_clear_enable_cfg |=> !master_clear_req)
    else $error("clear when disabled");

  // Outside slave mode strobes have no effect
  a_no_strobe: assert property (
    @(posedge mclk) disable iff (!nrst)
    !mode_r && !$past(mode_r) |-> !slave_bus_oe && !wr_end && !rd_end)
    else $error("strobe outside mode");

  // A CPU read of the word empties the input buffer
  a_input_full_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    (cpu_rd_word && !wr_end) |=> !input_buffer_full_r)
    else $error("input full stuck");

  // Overflow stays until software writes the control register
  a_overflow_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    input_overflow_r && !(reg_wr && reg_addr == port_e_pkg::ADDR_CTRL)
    |=> input_overflow_r) else $error("overflow dropped");

  // Overflow rises only on a write onto an unread word
  a_overflow_cause: assert property (
    @(posedge mclk) disable iff (!nrst)
    !input_overflow_r && !(wr_end && input_buffer_full_r)
    |=> !input_overflow_r) else $error("overflow without cause");

  // A CPU word outside a read fills the output buffer
  a_output_full_set: assert property (
    @(posedge mclk) disable iff (!nrst)
    (cpu_wr_word && !rd_active) |=> output_buffer_full_r)
    else $error("output full not set");

  // Mode bit takes the written value
  a_mode_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == port_e_pkg::ADDR_CTRL
    |=> mode_r == $past(reg_wdata[port_e_pkg::CTRL_MODE]))
    else $error("mode not written");

  // Direction bits take the written value
  a_dir_write: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == port_e_pkg::ADDR_CTRL
    |=> dir_r == $past(reg_wdata[2:0]))
    else $error("direction not written");

  // Software cannot write the buffer full flags
  a_flags_readonly: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == port_e_pkg::ADDR_CTRL && !wr_end && !rd_start
    |=> $stable(input_buffer_full_r) && $stable(output_buffer_full_r))
    else $error("flag written");

  // Latch register reads the latch, never the pins
  a_latch_read: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == port_e_pkg::ADDR_LATCH
    |=> reg_rdata == {5'h00, $past(latch_r)})
    else $error("latch read wrong");

  // Analog pins read zero
  a_analog_zero: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == port_e_pkg::ADDR_PIN_DATA
    |=> (reg_rdata[2:0] & $past(analog_select)) == 3'h0)
    else $error("analog pin read");

  // Small package shows no pins but the shared one
  a_small_hide: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == port_e_pkg::ADDR_PIN_DATA && small_package
    |=> reg_rdata[2:0] == 3'h0) else $error("hidden pins read");

  // Shared pin reads zero while it serves as reset input
  a_bit3_hidden: assert property (
    @(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == port_e_pkg::ADDR_PIN_DATA &&
    master_clear_enable_cfg |=> !reg_rdata[3]) else $error("bit 3 shown");

  // Data bus is driven once an external read is active
  a_read_oe: assert property (
    @(posedge mclk) disable iff (!nrst)
    rd_active |=> slave_bus_oe)
    else $error("bus not driven");

endmodule : port_e_io

// >>> tb/ext_master.sv
`timescale 1ns/10ps
module ext_master (
  input wire logic mclk,
  output port_e_pkg::strobe_s strb,
  output logic [7:0] bus_out,
  input wire logic [7:0] bus_in,
  input wire logic bus_oe
);
  // Idle: strobes released high, data bus shows inverse of last word
  initial begin
    strb = 3'h7;
    bus_out = 8'h00;
  end
  // Static line levels for plain port use
  task automatic set_lines(input logic [2:0] v);
    @(posedge mclk);
    strb <= v;
  endtask : set_lines
  // Write: select and write strobe low with data held until release
  task automatic put(input logic [7:0] d);
    @(posedge mclk);
    strb <= 3'h1;
    bus_out <= d;
    repeat (2) @(posedge mclk);
    strb <= 3'h7;
    bus_out <= ~d;
  endtask : put
  // Read: select and read strobe low, word taken before release
  task automatic get(output logic [7:0] q);
    @(posedge mclk);
    strb <= 3'h2;
    repeat (3) @(posedge mclk);
    q = bus_oe ? bus_in : 8'h00;
    strb <= 3'h7;
  endtask : get
endmodule : ext_master

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct {logic w; logic [2:0] a; logic [7:0] d, e;} row_s;
  logic mclk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, mce = 0, b3 = 1;
  logic small_package = 0;
  logic [2:0] reg_addr = 0, analog_select = 3'h7, pin_in, pin_out, pin_oe;
  logic [2:0] lines;
  logic [7:0] reg_wdata = 0, reg_rdata, sb_in, sb_out, q;
  logic sb_oe, irq, mc_req;
  port_e_pkg::strobe_s strb;
  int errors = 0, tests_run = 0, cycles = 0;
  row_s rows[8] = '{
    '{0, 3'h2, 8'h00, 8'h07}, '{0, 3'h1, 8'h00, 8'h00},
    '{0, 3'h0, 8'h00, 8'h08}, '{1, 3'h2, 8'hCF, 8'h07},
    '{1, 3'h1, 8'hFF, 8'h07}, '{1, 3'h2, 8'h00, 8'h00},
    '{0, 3'h0, 8'h00, 8'h08}, '{0, 3'h7, 8'h00, 8'h00}};
  always #50 mclk = ~mclk;
  // Wire level: driven pins show the latch, others the far side
  assign lines = strb;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & lines);
  port_e_io i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .small_package(small_package),
    .master_clear_enable_cfg(mce), .analog_select(analog_select),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_bit3_input(b3), .master_clear_req(mc_req),
    .slave_bus_in(sb_in), .slave_bus_out(sb_out), .slave_bus_oe(sb_oe),
    .irq(irq));
  ext_master i_ext (.mclk(mclk), .strb(strb), .bus_out(sb_in),
    .bus_in(sb_out), .bus_oe(sb_oe));
  task automatic final_report;
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask : rdc
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
  endtask : do_reset
  // Hang guard well above the length of the sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    chk("oe", 8'h07, {5'h0, pin_oe});
    chk("out", 8'h07, {5'h0, pin_out});
    wr(3'h2, 8'h07);
    analog_select <= 3'h0;
    i_ext.set_lines(3'h5);
    rdc(3'h0, 8'h0D);
    rdc(3'h1, 8'h07);
    small_package <= 1'b1;
    rdc(3'h0, 8'h08);
    small_package <= 1'b0;
    mce <= 1'b1;
    b3 <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("clear_req", 8'h01, {7'h0, mc_req});
    mce <= 1'b0;
    b3 <= 1'b1;
    i_ext.set_lines(3'h7);
    wr(3'h4, 8'h07);
    wr(3'h2, 8'h17);
    i_ext.put(8'hA5);
    repeat (2) @(posedge mclk);
    rdc(3'h2, 8'h97);
    chk("irq", 8'h01, {7'h0, irq});
    i_ext.put(8'h3C);
    repeat (2) @(posedge mclk);
    rdc(3'h2, 8'hB7);
    rdc(3'h6, 8'h3C);
    rdc(3'h2, 8'h37);
    wr(3'h2, 8'h17);
    rdc(3'h2, 8'h17);
    wr(3'h6, 8'h5A);
    rdc(3'h2, 8'h57);
    i_ext.get(q);
    chk("word", 8'h5A, q);
    repeat (2) @(posedge mclk);
    rdc(3'h2, 8'h17);
    rdc(3'h3, 8'h07);
    wr(3'h4, 8'h00);
    repeat (2) @(posedge mclk);
    chk("mask", 8'h00, {7'h0, irq});
    wr(3'h4, 8'h07);
    wr(3'h5, 8'h07);
    repeat (2) @(posedge mclk);
    chk("clr", 8'h00, {7'h0, irq});
    rdc(3'h3, 8'h00);
    do_reset();
    rdc(3'h2, 8'h07);
    final_report();
  end
endmodule : testbench
